// file: rtl/ptd_pkg.sv
// Package for the protection threshold and fault filter configuration bank
package ptd_pkg;
  // Register word indexes; the byte address on the bus is four times the index
  localparam logic [7:0]  OVL_IDX        = 8'h61;
  localparam logic [7:0]  UVL_IDX        = 8'h62;
  localparam logic [7:0]  FFT_IDX        = 8'h63;
  localparam logic [7:0]  SDO_IDX        = 8'h64;
  localparam logic [7:0]  OVR_OV_IDX     = 8'h7b;
  localparam logic [7:0]  OVR_UV_IDX     = 8'h7c;
  localparam logic [7:0]  SWOUT_IDX      = 8'h18;
  localparam logic [7:0]  IRQ_STAT_IDX   = 8'h80;
  localparam logic [7:0]  IRQ_MASK_IDX   = 8'h81;
  localparam logic [7:0]  FAULT_STAT_IDX = 8'h82;
  localparam int          ADDR_W         = 10;
  // Reset values
  localparam logic [7:0]  REG_RST        = 8'h00;
  // Field positions
  localparam int          SUP_SEL_LSB    = 0;
  localparam int          RAIL_LSB       = 2;
  localparam int          NRAIL          = 6;
  localparam int          FFT_SUP_BIT    = 7;
  localparam int          FFT_LIN_BIT    = 6;
  localparam int          FFT_RAIL_BIT   = 5;
  localparam int          FFT_HS_BIT     = 4;
  localparam int          FFT_EXT_BIT    = 3;
  localparam int          FFT_NORETRY    = 0;
  localparam int          SDO_PU_LVL     = 7;
  localparam int          SDO_PU_LSB     = 5;
  localparam int          SDO_PD_LSB     = 3;
  localparam int          SDO_SRC_BIT    = 2;
  localparam int          SDO_RSRC_BIT   = 0;
  localparam int          SWOUT_SD_BIT   = 7;
  // Trip level codes: percent of nominal, supply in tenths of a volt
  localparam logic [6:0]  OV_PCT_LO      = 7'd110;
  localparam logic [6:0]  OV_PCT_HI      = 7'd115;
  localparam logic [6:0]  OV_PCT_FORCE   = 7'd120;
  localparam logic [6:0]  UV_PCT_LO      = 7'd90;
  localparam logic [6:0]  UV_PCT_HI      = 7'd85;
  localparam logic [6:0]  UV_PCT_FORCE   = 7'd80;
  localparam logic [7:0]  SUP_OV_DV0     = 8'd140;
  localparam logic [7:0]  SUP_OV_DV1     = 8'd150;
  localparam logic [7:0]  SUP_OV_DV2     = 8'd160;
  localparam logic [7:0]  SUP_OV_DV3     = 8'd170;
  localparam logic [7:0]  SUP_UV_DV0     = 8'd38;
  localparam logic [7:0]  SUP_UV_DV1     = 8'd43;
  localparam logic [7:0]  SUP_UV_DV2     = 8'd60;
  localparam logic [7:0]  SUP_UV_DV3     = 8'd80;
  // Filter timing
  localparam int          CLK_MHZ        = 100;
  localparam int          FILT_SHORT_US  = 5;
  localparam int          FILT_LONG_US   = 10;
  localparam int          CYC_SHORT      = FILT_SHORT_US * CLK_MHZ;
  localparam int          CYC_LONG       = FILT_LONG_US * CLK_MHZ;
  localparam int          CNT_W          = 10;
  // Filter channels
  localparam int          NCH            = 7;
  localparam int          CH_SUP         = 0;
  localparam int          CH_LIN         = 1;
  localparam int          CH_RAIL        = 2;
  localparam int          CH_SDREQ       = 3;
  localparam int          CH_SDACK       = 4;
  localparam int          CH_EXT         = 5;
  localparam int          CH_RETRY       = 6;

  typedef struct packed {
    logic [NRAIL-1:0][6:0] rail_ov_pct;
    logic [NRAIL-1:0][6:0] rail_uv_pct;
    logic [7:0]            supply_ov_dv;
    logic [7:0]            supply_uv_dv;
  } ptd_trip_type;

  typedef struct packed {
    logic       level_1v8;
    logic [1:0] strength;
    logic       enable;
  } ptd_pullup_type;
endpackage

// file: rtl/ptd_bank.sv
// Protection threshold, fault filter and shutdown pin configuration bank
// Overview of operation
// RULE1 - Rail high trip bit: 110 or 115 percent
// RULE2 - Override bit forces 120 percent high trip
// RULE3 - Supply high trip code: 14 to 17 V
// RULE4 - Rail low trip bit: 90 or 85 percent
// RULE5 - Override bit forces 80 percent low trip
// RULE6 - Supply low trip code: 3.8/4.3/6/8 V
// RULE7 - Supply fault filter 5 or 10 us
// RULE8 - Linear reg filter 5 us or bypassed
// RULE9 - Rail fault filter 5 us or bypassed
// RULE10 - Handshake request/ack filter 5 or 10 us
// RULE11 - External good filter only on input pins; the code filters it 5 us on output pins too, 10 us only on input pins
// RULE12 - Retry timer runs unless disable bit set
// RULE13 - Shutdown out buffers request or software bit
// RULE14 - Pullup fields apply only while gating bit zero
// RULE15 - Resistor source: internal or external pullup
// RULE16 - Fault reported after continuous persistence, else restart
// RULE17 - Reserved bits store written value, no effect
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ptd_bank
  import ptd_pkg::*;
#(
  parameter int RETRY_CYC = 1000
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Raw comparator and pin inputs
  input  wire logic                  supply_fault_raw,
  input  wire logic                  linear_reg_fault_raw,
  input  wire logic                  rail_fault_raw,
  input  wire logic                  shutdown_request_in,
  input  wire logic                  shutdown_acknowledge,
  input  wire logic                  ext_regulator_good,
  input  wire logic                  ext_good_is_input,
  input  wire logic                  retry_start,
  // Filtered results
  output logic      [NCH-2:0]        fault_filtered,
  output logic                       retry_done,
  output logic                       retry_active,
  // Analog trim outputs
  output ptd_trip_type               trip,
  output ptd_pullup_type             shutdown_out_pullup,
  output logic      [1:0]            shutdown_out_pulldown_strength,
  output logic                       shutdown_out_resistor_source,
  // Shutdown output pin
  output logic                       shutdown_request_out,
  output logic                       shutdown_request_out_oe,
  // Interrupt
  output logic                       irq
);

  // Storage
  logic [7:0]                ovl_reg;
  logic [7:0]                ovl_next;
  logic [7:0]                uvl_reg;
  logic [7:0]                uvl_next;
  logic [7:0]                fft_reg;
  logic [7:0]                fft_next;
  logic [7:0]                sdo_reg;
  logic [7:0]                sdo_next;
  logic [7:0]                ovr_ov_reg;
  logic [7:0]                ovr_ov_next;
  logic [7:0]                ovr_uv_reg;
  logic [7:0]                ovr_uv_next;
  logic [7:0]                swout_reg;
  logic [7:0]                swout_next;
  logic [7:0]                mask_reg;
  logic [7:0]                mask_next;
  logic [7:0]                stat_reg;
  logic [7:0]                stat_next;
  logic [31:0]               prdata_reg;
  logic [31:0]               prdata_next;
  logic [NCH-1:0]            sync1_reg;
  logic [NCH-1:0]            sync2_reg;
  logic [NCH-1:0]            filt_reg;
  logic [NCH-1:0]            filt_next;
  logic [NCH-1:0][CNT_W-1:0] cnt_reg;
  logic [NCH-1:0][CNT_W-1:0] cnt_next;
  logic [NCH-1:0]            raw;
  logic [NCH-1:0]            bypass;
  logic [NCH-1:0]            long_sel;
  logic [NCH-1:0]            filt_prev_reg;
  logic [15:0]               retry_cnt_reg;
  logic [15:0]               retry_cnt_next;
  logic                      retry_act_reg;
  logic                      retry_act_next;
  logic                      retry_done_reg;
  logic                      retry_done_next;
  logic                      sdo_pin_reg;
  logic                      sdo_pin_next;
  logic                      wr_en;
  logic                      rd_en;
  logic                      rd_setup;
  logic                      hit;
  logic [7:0]                idx;
  logic [7:0]                events;

  function automatic logic [7:0] sup_ov(input logic [1:0] c);
    unique case (c)
      2'h0:    sup_ov = SUP_OV_DV0;
      2'h1:    sup_ov = SUP_OV_DV1;
      2'h2:    sup_ov = SUP_OV_DV2;
      default: sup_ov = SUP_OV_DV3;
    endcase
  endfunction

  function automatic logic [7:0] sup_uv(input logic [1:0] c);
    unique case (c)
      2'h0:    sup_uv = SUP_UV_DV0;
      2'h1:    sup_uv = SUP_UV_DV1;
      2'h2:    sup_uv = SUP_UV_DV2;
      default: sup_uv = SUP_UV_DV3;
    endcase
  endfunction

  // APB decode; zero-wait answer, word index is bits 9:2 of the address
  assign idx     = paddr[9:2];
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_reg;

  always_comb begin
    unique case (idx)
      OVL_IDX, UVL_IDX, FFT_IDX, SDO_IDX, OVR_OV_IDX, OVR_UV_IDX, SWOUT_IDX,
      IRQ_STAT_IDX, IRQ_MASK_IDX, FAULT_STAT_IDX: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Sticky event capture: rising edges of filtered faults and retry expiry
  assign events = {1'b0, retry_done_reg, filt_reg[NCH-2:0] & ~filt_prev_reg[NCH-2:0]};

  always_comb begin
    ovl_next    = ovl_reg;
    uvl_next    = uvl_reg;
    fft_next    = fft_reg;
    sdo_next    = sdo_reg;
    ovr_ov_next = ovr_ov_reg;
    ovr_uv_next = ovr_uv_reg;
    swout_next  = swout_reg;
    mask_next   = mask_reg;
    stat_next   = stat_reg;
    prdata_next = prdata_reg;
    // Reserved bits are stored as written and steer nothing [RULE17]
    if (wr_en) begin
      unique case (idx)
        OVL_IDX:      ovl_next    = pwdata[7:0];
        UVL_IDX:      uvl_next    = pwdata[7:0];
        FFT_IDX:      fft_next    = pwdata[7:0];
        SDO_IDX:      sdo_next    = pwdata[7:0];
        OVR_OV_IDX:   ovr_ov_next = pwdata[7:0];
        OVR_UV_IDX:   ovr_uv_next = pwdata[7:0];
        SWOUT_IDX:    swout_next  = pwdata[7:0];
        IRQ_MASK_IDX: mask_next   = pwdata[7:0];
        default:      ;
      endcase
    end
    // Read data is latched in the setup phase, so it already stands at the access edge
    if (rd_setup) begin
      prdata_next = 32'h0000_0000;
      unique case (idx)
        OVL_IDX:        prdata_next[7:0] = ovl_reg;
        UVL_IDX:        prdata_next[7:0] = uvl_reg;
        FFT_IDX:        prdata_next[7:0] = fft_reg;
        SDO_IDX:        prdata_next[7:0] = sdo_reg;
        OVR_OV_IDX:     prdata_next[7:0] = ovr_ov_reg;
        OVR_UV_IDX:     prdata_next[7:0] = ovr_uv_reg;
        SWOUT_IDX:      prdata_next[7:0] = swout_reg;
        IRQ_MASK_IDX:   prdata_next[7:0] = mask_reg;
        FAULT_STAT_IDX: prdata_next[7:0] = {1'b0, retry_act_reg, filt_reg[NCH-2:0]};
        IRQ_STAT_IDX:   prdata_next[7:0] = stat_reg;
        default:        ;
      endcase
    end
    // Clear only the bits that were reported; an event after the setup phase survives
    if (rd_en && (idx == IRQ_STAT_IDX)) begin
      stat_next = stat_reg & ~prdata_reg[7:0];
    end
    // A new event in the clearing cycle wins
    stat_next = stat_next | events;
  end

  // Trip level decode
  // Override bits win over the ordinary selection bits
  always_comb begin
    trip = '0;
    for (int i = 0; i < NRAIL; i++) begin
      if (ovr_ov_reg[RAIL_LSB+i])
        trip.rail_ov_pct[i] = OV_PCT_FORCE;                                   // [RULE2]
      else
        trip.rail_ov_pct[i] = ovl_reg[RAIL_LSB+i] ? OV_PCT_HI : OV_PCT_LO;   // [RULE1]
      if (ovr_uv_reg[RAIL_LSB+i])
        trip.rail_uv_pct[i] = UV_PCT_FORCE;                                   // [RULE5]
      else
        trip.rail_uv_pct[i] = uvl_reg[RAIL_LSB+i] ? UV_PCT_HI : UV_PCT_LO;   // [RULE4]
    end
    trip.supply_ov_dv = sup_ov(ovl_reg[SUP_SEL_LSB+:2]);                      // [RULE3]
    trip.supply_uv_dv = sup_uv(uvl_reg[SUP_SEL_LSB+:2]);                      // [RULE6]
  end

  // Pin configuration; bit 4, shared with the pulldown field, gates the pullup fields
  always_comb begin
    shutdown_out_pullup.enable    = !sdo_reg[SDO_PD_LSB+1];                   // [RULE14]
    shutdown_out_pullup.level_1v8 = sdo_reg[SDO_PU_LVL] & !sdo_reg[SDO_PD_LSB+1];
    shutdown_out_pullup.strength  = sdo_reg[SDO_PD_LSB+1] ? 2'h0 : sdo_reg[SDO_PU_LSB+:2];
  end
  assign shutdown_out_pulldown_strength = sdo_reg[SDO_PD_LSB+:2];
  assign shutdown_out_resistor_source   = sdo_reg[SDO_RSRC_BIT];              // [RULE15]

  // Filter channel setup
  // Pin levels reach the filters only through the two synchroniser flops
  always_comb begin
    raw           = {1'b0, ext_regulator_good, shutdown_acknowledge, shutdown_request_in,
                     rail_fault_raw, linear_reg_fault_raw, supply_fault_raw};
    bypass        = '0;
    long_sel      = '0;
    long_sel[CH_SUP]   = fft_reg[FFT_SUP_BIT];                                // [RULE7]
    bypass[CH_LIN]     = fft_reg[FFT_LIN_BIT];                                // [RULE8]
    bypass[CH_RAIL]    = fft_reg[FFT_RAIL_BIT];                               // [RULE9]
    long_sel[CH_SDREQ] = fft_reg[FFT_HS_BIT];                                 // [RULE10]
    long_sel[CH_SDACK] = fft_reg[FFT_HS_BIT];                                 // [RULE10]
    long_sel[CH_EXT]   = fft_reg[FFT_EXT_BIT] & ext_good_is_input;            // [RULE11]
    bypass[CH_RETRY]   = 1'b1;
  end

  // Persistence filter per channel; any return to the settled value restarts [RULE16]
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cnt_next[i]  = cnt_reg[i];
      filt_next[i] = filt_reg[i];
      if (bypass[i]) begin
        filt_next[i] = sync2_reg[i];
        cnt_next[i]  = '0;
      end else if (sync2_reg[i] == filt_reg[i]) begin
        cnt_next[i]  = '0;
      end else if (cnt_reg[i] == CNT_W'((long_sel[i] ? CYC_LONG : CYC_SHORT) - 1)) begin
        filt_next[i] = sync2_reg[i];
        cnt_next[i]  = '0;
      end else begin
        cnt_next[i]  = cnt_reg[i] + CNT_W'(1);
      end
    end
  end

  // Retry timer
  // Setting the disable bit also drops a run in progress
  always_comb begin
    retry_cnt_next  = retry_cnt_reg;
    retry_act_next  = retry_act_reg;
    retry_done_next = 1'b0;
    if (fft_reg[FFT_NORETRY]) begin
      retry_act_next = 1'b0;                                                  // [RULE12]
      retry_cnt_next = '0;
    end else if (retry_act_reg) begin
      if (retry_cnt_reg == 16'(RETRY_CYC - 1)) begin
        retry_act_next  = 1'b0;
        retry_done_next = 1'b1;
        retry_cnt_next  = '0;
      end else begin
        retry_cnt_next = retry_cnt_reg + 16'h0001;
      end
    end else if (retry_start) begin
      retry_act_next = 1'b1;                                                  // [RULE12]
    end
  end

  // Shutdown output source
  always_comb begin
    sdo_pin_next = sdo_reg[SDO_SRC_BIT] ? swout_reg[SWOUT_SD_BIT]
                                        : filt_reg[CH_SDREQ];                 // [RULE13]
  end

  // Clock enable low freezes every register, bus writes included
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovl_reg        <= REG_RST;
      uvl_reg        <= REG_RST;
      fft_reg        <= REG_RST;
      sdo_reg        <= REG_RST;
      ovr_ov_reg     <= REG_RST;
      ovr_uv_reg     <= REG_RST;
      swout_reg      <= REG_RST;
      mask_reg       <= REG_RST;
      stat_reg       <= REG_RST;
      prdata_reg     <= '0;
      sync1_reg      <= '0;
      sync2_reg      <= '0;
      filt_reg       <= '0;
      filt_prev_reg  <= '0;
      cnt_reg        <= '0;
      retry_cnt_reg  <= '0;
      retry_act_reg  <= 1'b0;
      retry_done_reg <= 1'b0;
      sdo_pin_reg    <= 1'b0;
    end else if (clk_en) begin
      ovl_reg        <= ovl_next;
      uvl_reg        <= uvl_next;
      fft_reg        <= fft_next;
      sdo_reg        <= sdo_next;
      ovr_ov_reg     <= ovr_ov_next;
      ovr_uv_reg     <= ovr_uv_next;
      swout_reg      <= swout_next;
      mask_reg       <= mask_next;
      stat_reg       <= stat_next;
      prdata_reg     <= prdata_next;
      sync1_reg      <= raw;
      sync2_reg      <= sync1_reg;
      filt_reg       <= filt_next;
      filt_prev_reg  <= filt_reg;
      cnt_reg        <= cnt_next;
      retry_cnt_reg  <= retry_cnt_next;
      retry_act_reg  <= retry_act_next;
      retry_done_reg <= retry_done_next;
      sdo_pin_reg    <= sdo_pin_next;
    end
  end

  assign fault_filtered          = filt_reg[NCH-2:0];
  assign retry_done              = retry_done_reg;
  assign retry_active            = retry_act_reg;
  assign shutdown_request_out    = sdo_pin_reg;
  // Pin is a push-pull output in both source modes
  assign shutdown_request_out_oe = 1'b1;
  assign irq                     = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

// file: sim/ptd_bank_properties.sv
// Checker for the protection threshold and filter configuration bank
`timescale 1ns/1ps
`default_nettype none
module ptd_bank_properties
  import ptd_pkg::*;
#(
  parameter int RETRY_CYC = 1000
) (
  // Clock, reset and bus
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pslverr,
  // Filter and timer
  input wire logic              supply_fault_raw,
  input wire logic [NCH-2:0]    fault_filtered,
  input wire logic              retry_active,
  // Trim outputs
  input wire ptd_trip_type      trip,
  input wire ptd_pullup_type    shutdown_out_pullup,
  input wire logic [1:0]        shutdown_out_pulldown_strength,
  input wire logic              shutdown_out_resistor_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic        wr;
  logic [10:0] hi_cnt;
  logic [10:0] hi_next;
  logic [10:0] act_cnt;
  logic [10:0] act_next;
  assign wr = psel && penable && pwrite && clk_en;
  function automatic logic [7:0] uv_dv(input logic [1:0] c);
    return c[1] ? (c[0] ? 8'd80 : 8'd60) : (c[0] ? 8'd43 : 8'd38);
  endfunction
  // Saturating run lengths, so a long fault never wraps into a false short count
  always_comb begin
    hi_next = supply_fault_raw ? hi_cnt + 11'h1 : 11'h0;
    act_next = retry_active ? act_cnt + 11'h1 : 11'h0;
    if (hi_cnt == 11'h7ff) hi_next = hi_cnt;
    if (act_cnt == 11'h7ff) act_next = act_cnt;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= 11'h0;
      act_cnt <= 11'h0;
    end else begin
      hi_cnt <= hi_next;
      act_cnt <= act_next;
    end
  end
  property p_unmapped; psel && penable && paddr == 10'h3fc |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");
  property p_sup_ov; wr && paddr == 10'h184 |=> trip.supply_ov_dv ==
    8'd140 + 8'd10 * $past(pwdata[1:0]); endproperty
  a_sup_ov: assert property (p_sup_ov) else $error("supply high trip wrong");
  property p_sup_uv;
    wr && paddr == 10'h188 |=> trip.supply_uv_dv == uv_dv($past(pwdata[1:0]));
  endproperty
  a_sup_uv: assert property (p_sup_uv) else $error("supply low trip wrong");
  property p_ov_force; wr && paddr == 10'h1ec && pwdata[2] |=> trip.rail_ov_pct[0] == 7'd120;
  endproperty
  a_ov_force: assert property (p_ov_force) else $error("high trip not forced");
  property p_uv_force; wr && paddr == 10'h1f0 && pwdata[7] |=> trip.rail_uv_pct[5] == 7'd80;
  endproperty
  a_uv_force: assert property (p_uv_force) else $error("low trip not forced");
  property p_pu_gate; wr && paddr == 10'h190 && pwdata[4] |=> shutdown_out_pullup == 4'h0;
  endproperty
  a_pu_gate: assert property (p_pu_gate) else $error("pullup not gated");
  property p_pu_set; wr && paddr == 10'h190 && !pwdata[4] |=>
    {shutdown_out_pullup, shutdown_out_pulldown_strength, shutdown_out_resistor_source} ==
    {$past(pwdata[7:5]), 1'b1, $past(pwdata[4:3]), $past(pwdata[0])}; endproperty
  a_pu_set: assert property (p_pu_set) else $error("pin fields wrong");
  property p_filt; $rose(fault_filtered[0]) |-> $past(hi_cnt, 3) >= 11'd495; endproperty
  a_filt: assert property (p_filt) else $error("supply fault reported early");
  property p_retry; retry_active |-> act_cnt < 11'(RETRY_CYC + 4); endproperty
  a_retry: assert property (p_retry) else $error("retry timer overran");
  c_pin_write: cover property (wr && paddr == 10'h190);
  c_filt: cover property ($rose(fault_filtered[0]));
  c_retry: cover property ($fell(retry_active));
endmodule
bind ptd_bank ptd_bank_properties #(.RETRY_CYC(RETRY_CYC)) u_ptd_bank_properties (
  .clk, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .supply_fault_raw, .fault_filtered, .retry_active, .trip, .shutdown_out_pullup,
  .shutdown_out_pulldown_strength, .shutdown_out_resistor_source
);
`default_nettype wire

// file: sim/ptd_bank_tb_top.sv
// Self-checking bench for the protection configuration bank
`timescale 1ns/1ps
`default_nettype none
module ptd_bank_tb_top
  import ptd_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, sd_out, sd_oe, seen;
  logic ext_in, retry_start, retry_done, retry_active, irq, rsrc, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [7:0] u;
  logic [5:0] raw, filt;
  logic [1:0] pd;
  ptd_trip_type trip;
  ptd_pullup_type pu;
  int n_errors, checked, cnt, dn;
  logic [31:0] tab [12] = '{32'h0000_01f4, 32'h8000_03e8, 32'h4010_0000, 32'h0010_01f4,
    32'h2020_0000, 32'h0020_01f4, 32'h1030_03e8, 32'h0040_01f4, 32'h1040_03e8,
    32'h0850_01f4, 32'h0851_03e8, 32'h0600_01f4};
  ptd_bank #(.RETRY_CYC(8)) u_ptd_bank (
    .clk, .reset_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_fault_raw(raw[0]), .linear_reg_fault_raw(raw[1]),
    .rail_fault_raw(raw[2]), .shutdown_request_in(raw[3]), .shutdown_acknowledge(raw[4]),
    .ext_regulator_good(raw[5]), .ext_good_is_input(ext_in), .retry_start,
    .fault_filtered(filt), .retry_done, .retry_active, .trip, .shutdown_out_pullup(pu),
    .shutdown_out_pulldown_strength(pd), .shutdown_out_resistor_source(rsrc),
    .shutdown_request_out(sd_out), .shutdown_request_out_oe(sd_oe), .irq
  );
  always #5 clk = ~clk;
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bound(input int lim);
    if (cnt >= lim) begin
      chk(cnt, lim - 1);
      report_and_stop();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (pready !== 1'b1 && cnt < 20);
    bound(20);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic ptd_trip_type exp_trip(input logic [7:0] ov, uv, oo, ou);
    ptd_trip_type t;
    for (int i = 0; i < NRAIL; i++) begin
      t.rail_ov_pct[i] = oo[i+2] ? 7'd120 : (ov[i+2] ? 7'd115 : 7'd110);
      t.rail_uv_pct[i] = ou[i+2] ? 7'd80 : (uv[i+2] ? 7'd85 : 7'd90);
    end
    t.supply_ov_dv = 8'd140 + 8'd10 * ov[1:0];
    t.supply_uv_dv = uv[1] ? (uv[0] ? 8'd80 : 8'd60) : (uv[0] ? 8'd43 : 8'd38);
    return t;
  endfunction
  // Raw fault rises; the filtered level must follow after the chosen time, not sooner
  task automatic filt_case(input logic [7:0] f, input int ch, input logic ei, input int e);
    apb(1'b1, 10'h18c, {24'h0, f});
    ext_in <= ei;
    raw[ch] <= 1'b1;
    cnt = 0;
    do begin
      tick(1);
      cnt++;
    end while (filt[ch] !== 1'b1 && cnt < 1200);
    bound(1200);
    chk(cnt >= e && cnt <= e + 6, 1'b1);
    tick(2);
    chk({irq, sd_out}, {1'b1, ch == 3});
    rdchk(10'h208, 32'h1 << ch);
    rdchk(10'h200, 32'h1 << ch);
    tick(1);
    chk(irq, 1'b0);
    raw[ch] <= 1'b0;
    tick(1210);
    chk(filt, 6'h0);
  endtask
  initial begin
    {clk, reset_n, psel, penable, pwrite, retry_start, ext_in, raw, paddr, pwdata} = '0;
    {n_errors, checked} = '0;
    void'($urandom(32'h00282fa2));
    tick(20);
    reset_n <= 1'b1;
    chk({trip, sd_oe}, {exp_trip(8'h0, 8'h0, 8'h0, 8'h0), 1'b1});
    for (int k = 0; k < 16; k++) begin
      v = (k == 0) ? 32'h0 : (k == 1) ? 32'hffff_ffff : $urandom;
      apb(1'b1, 10'h184, v);
      apb(1'b1, 10'h188, {v[7:0], v[31:8]});
      apb(1'b1, 10'h1ec, {v[15:0], v[31:16]});
      apb(1'b1, 10'h1f0, {v[23:0], v[31:24]});
      chk(trip, exp_trip(v[7:0], v[15:8], v[23:16], v[31:24]));
      rdchk(10'h184, {24'h0, v[7:0]});
      rdchk(10'h1f0, {24'h0, v[31:24]});
      u = (k == 0) ? 8'hef : (k == 1) ? 8'hff : 8'($urandom);
      apb(1'b1, 10'h190, {24'h0, u});
      chk({pu, pd, rsrc}, u[4] ? {4'h0, u[4:3], u[0]} : {u[7:5], 1'b1, u[4:3], u[0]});
      rdchk(10'h190, {24'h0, u});
      chk(err, 1'b0);
      apb(1'b1, 10'h18c, {24'h0, u});
      rdchk(10'h18c, {24'h0, u});
    end
    $display("register test done");
    apb(1'b1, 10'h3fc, 32'hffff_ffff);
    rdchk(10'h3fc, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 10'h190, 32'h4);
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 10'h060, {24'h0, b[0], 7'h0});
      tick(2);
      chk(sd_out, b[0]);
    end
    apb(1'b1, 10'h190, 32'h0);
    tick(2);
    chk(sd_out, 1'b0);
    $display("pin test done");
    apb(1'b1, 10'h204, 32'h7f);
    apb(1'b1, 10'h18c, 32'h0);
    raw[0] <= 1'b1;
    tick(300);
    raw[0] <= 1'b0;
    chk(filt[0], 1'b0);
    tick(5);
    foreach (tab[i]) filt_case(tab[i][31:24], tab[i][23:20], tab[i][16], tab[i][15:0]);
    $display("filter test done");
    apb(1'b1, 10'h204, 32'h0);
    apb(1'b1, 10'h18c, 32'h20);
    raw[2] <= 1'b1;
    tick(10);
    chk(irq, 1'b0);
    apb(1'b1, 10'h204, 32'h4);
    tick(1);
    chk(irq, 1'b1);
    rdchk(10'h200, 32'h4);
    tick(1);
    chk(irq, 1'b0);
    raw[2] <= 1'b0;
    $display("interrupt test done");
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, 10'h18c, {31'h0, b[0]});
      retry_start <= 1'b1;
      tick(1);
      retry_start <= 1'b0;
      seen = 1'b0;
      dn = 0;
      for (cnt = 0; cnt < 30; cnt++) begin
        tick(1);
        seen = seen | retry_active;
        dn += int'(retry_done);
      end
      chk({seen, retry_active}, {!b[0], 1'b0});
      chk(dn, !b[0]);
    end
    $display("retry test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
